// ### logic/fss_pkg.sv
/*
 Shared constants and carrier types for the scan, seek and drive-status
 command block. Assumes a 10 MHz clock and a Wishbone register bus.
*/
`default_nettype none
package fss_pkg;
	// ****************
	// Bus map
	// ****************
	localparam logic [3:0] FSS_ADR_DATA = 4'h0;
	localparam logic [3:0] FSS_ADR_MSR = 4'h4;
	localparam logic [3:0] FSS_ADR_CFG = 4'h8;
	localparam logic [3:0] FSS_ADR_DRV = 4'hc;
	// ****************
	// Opcodes and fields
	// ****************
	localparam logic [4:0] FSS_OP_SCAN_EQ = 5'h11;
	localparam logic [4:0] FSS_OP_SCAN_LE = 5'h19;
	localparam logic [4:0] FSS_OP_SCAN_HE = 5'h1d;
	localparam logic [7:0] FSS_OP_SEEK = 8'h0f;
	localparam logic [4:0] FSS_OP_SDS = 5'h04;
	localparam logic [7:0] FSS_WILD = 8'hff;
	localparam int FSS_SR2_EQ_BIT = 2;
	localparam int FSS_SR2_NOT_BIT = 3;
	localparam int FSS_MSR_RQM_BIT = 7;
	localparam int FSS_MSR_DIO_BIT = 6;
	localparam int FSS_MSR_CB_BIT = 4;
	localparam logic [7:0] FSS_ST0_SEEK_END = 8'h20;
	localparam logic [3:0] FSS_SCAN_CMD_LEN = 4'h9;
	localparam logic [2:0] FSS_SCAN_RES_LEN = 3'h7;
	// ****************
	// Timing
	// ****************
	localparam int FSS_CLK_KHZ = 10000;
	localparam int FSS_STEP_PULSE_US = 1;
	localparam logic [3:0] FSS_STEP_PULSE_CYC =
		4'((FSS_STEP_PULSE_US * FSS_CLK_KHZ + 999) / 1000);
	localparam logic [23:0] FSS_RESET_UNIT = 24'h000000;

	typedef enum logic [2:0] {
		FSS_IDLE = 3'b000,
		FSS_CMD = 3'b001,
		FSS_SCAN = 3'b010,
		FSS_RES = 3'b011,
		FSS_MOTOR = 3'b100
	} fss_phase_t;

	typedef struct packed {
		logic [7:0] track;
		logic [3:0] track_hi;
		logic [23:0] cnt;
		logic stepping;
		logic dir;
		logic busy;
	} fss_drive_t;

	typedef struct packed {
		fss_phase_t phase;
		logic [3:0] idx;
		logic [7:0] op;
		logic [1:0] drv;
		logic head;
		logic [7:0] trk;
		logic [3:0] trk_hi;
		logic [7:0] sec;
		logic [7:0] size;
		logic [7:0] last;
		logic [7:0] step;
		logic eq_ok;
		logic lt;
		logic gt;
		logic hit;
		logic skip_all;
		logic [7:0] st2;
		logic [23:0] mcnt;
		logic [7:0] rdat;
		logic ack;
		logic irq;
		logic [3:0] pcnt;
		logic step_out;
		logic dir_out;
		fss_drive_t [3:0] d;
	} fss_state_t;
endpackage
`default_nettype wire

// ### logic/fss_core.sv
/*
 Command interpreter for scan, seek and sense-drive-status.
 Assumes one 10 MHz clock, sync reset, a classic Wishbone master,
 a disk byte stream from the data separator, and drive pins on inputs.
*/
// Function
// [R1] Compare host bytes to disk bytes for equal, high-or-equal, low-or-equal
// [R2] Host writes nine scan bytes in fixed order
// [R3] Scan returns seven result bytes: three statuses, track, head, sector, size
// [R4] Status bits 2 and 3 encode equal, strict or not met
// [R5] Compare MSB first, step sectors, stop on hit, last sector or count
// [R6] Wildcard mode makes an all-ones byte from either side match
// [R7] Seek compares tracks, counts steps and drives direction toward target
// [R8] Accepting a seek sets that drive's busy flag
// [R9] Wait the motor-on interval before the first step
// [R10] Steps run from drive polling so commands are accepted meanwhile
// [R11] Steps spaced by the programmed step rate interval
// [R12] Interrupt one step period after the final step pulse
// [R13] Host issues sense-interrupt after a seek interrupt
// [R14] Seek has no result bytes
// [R15] Several drives may seek at once; the core keeps one shared target track for all drives
// [R16] Host keeps one drive seeking at a time
// [R17] During a seek host issues only sense-interrupt
// [R18] Extended range adds a fourth seek byte, upper nibble is track MSN
// [R19] Seek opcode 0x0f, second byte head and drive, third track
// [R20] Drive-status query returns status three without interrupt
// [R21] Skip flag drops deleted sectors, all skipped ends with bit 3 set
`timescale 1ns/10ps
`default_nettype none
module fss_core
	import fss_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic disk_valid_i,
	input wire logic [7:0] disk_byte_i,
	input wire logic disk_deleted_i,
	input wire logic disk_sector_end_i,
	input wire logic terminal_count_i,
	input wire logic track_zero_i,
	input wire logic [3:0] drive_pins_i,
	output logic step_o,
	output logic dir_o,
	output logic irq_o
);
	// ****************
	// Pin sync and config
	// ****************
	logic [1:0] tc_s, t0_s;
	logic [3:0] dp_m, dp_s;
	logic [7:0] cfg_reg;
	logic [23:0] unit_reg;
	fss_state_t s_reg, s_next;

	always_ff @(posedge clk_i)
	begin
		tc_s <= {tc_s[0], terminal_count_i};
		t0_s <= {t0_s[0], track_zero_i};
		dp_m <= drive_pins_i;
		dp_s <= dp_m;
	end

	function automatic logic wild(input logic en, input logic [7:0] a,
		input logic [7:0] b);
		wild = en && (a == FSS_WILD || b == FSS_WILD);
	endfunction

	logic wr, rd, data_sel;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack && wb_sel_i[0];
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack;
	assign data_sel = wb_adr_i == FSS_ADR_DATA;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_reg <= 8'h00;
			unit_reg <= FSS_RESET_UNIT;
		end
		else if (wr && wb_adr_i == FSS_ADR_CFG)
			cfg_reg <= wb_dat_i[7:0];
		else if (wr && wb_adr_i == FSS_ADR_DRV && wb_sel_i == 4'hf)
			unit_reg <= wb_dat_i[23:0];
	end
	// cfg: [7:4] step rate units, [3] extended range, [2] wildcard
	// unit_reg: cycles per step-rate unit, also motor-on unit

	logic [7:0] st3;
	assign st3 = {1'b0, 1'b0, 1'b1, t0_s[1], dp_s[3], s_reg.head,
		s_reg.drv};

	// ****************
	// Next state
	// ****************
	logic [7:0] host_b;
	logic done_scan;
	assign host_b = wb_dat_i[7:0];

	always_comb
	begin
		s_next = s_reg;
		s_next.ack = (wb_cyc_i && wb_stb_i) && !s_reg.ack;
		s_next.rdat = 8'h00;
		done_scan = 1'b0;
		if (rd)
			case (wb_adr_i)
				FSS_ADR_MSR: s_next.rdat = {s_reg.phase == FSS_IDLE ||
					s_reg.phase == FSS_CMD || s_reg.phase == FSS_RES
					|| s_reg.phase == FSS_SCAN,
					s_reg.phase == FSS_RES,
					1'b0, s_reg.phase != FSS_IDLE,
					s_reg.d[3].busy, s_reg.d[2].busy,
					s_reg.d[1].busy, s_reg.d[0].busy};
				FSS_ADR_CFG: s_next.rdat = cfg_reg;
				FSS_ADR_DATA: if (s_reg.phase == FSS_RES)
					case (s_reg.idx)
						4'h0: s_next.rdat = {5'h00, s_reg.head, s_reg.drv};
						4'h1: s_next.rdat = 8'h00;
						4'h2: s_next.rdat = s_reg.st2;
						4'h3: s_next.rdat = s_reg.trk;
						4'h4: s_next.rdat = {7'h00, s_reg.head};
						4'h5: s_next.rdat = s_reg.sec;
						4'h6: s_next.rdat = s_reg.size;
						4'h8: s_next.rdat = st3;
						default: s_next.rdat = 8'h00;
					endcase
				default: s_next.rdat = 8'h00;
			endcase
		case (s_reg.phase)
			FSS_IDLE:
				if (wr && data_sel)
				begin
					s_next.op = host_b;
					s_next.idx = 4'h1;
					s_next.phase = FSS_CMD;
				end
				else if (rd && data_sel)
					s_next.irq = 1'b0;
			FSS_CMD:
				if (wr && data_sel)
				begin
					s_next.idx = s_reg.idx + 4'h1;
					case (s_reg.idx)
						4'h1:
						begin
							s_next.drv = host_b[1:0];
							s_next.head = host_b[2];
						end
						4'h2: s_next.trk = host_b;
						4'h3: s_next.trk_hi = host_b[7:4];
						4'h4: s_next.sec = host_b;
						4'h5: s_next.size = host_b;
						4'h6: s_next.last = host_b;
						4'h8: s_next.step = host_b;
						default: s_next.step = s_reg.step;
					endcase
					// [R19] seek byte layout
					if (s_reg.op == FSS_OP_SEEK)
					begin
						if (s_reg.idx == 4'h2)
							s_next.trk_hi = 4'h0;
						// [R18] fourth seek byte
						if ((s_reg.idx == 4'h2 && !cfg_reg[3]) ||
							s_reg.idx == 4'h3)
						begin
							s_next.phase = FSS_MOTOR;
							s_next.mcnt = unit_reg;
						end
					end
					// [R2] nine scan bytes
					else if (s_reg.idx == FSS_SCAN_CMD_LEN - 4'h1)
					begin
						s_next.phase = FSS_SCAN;
						s_next.eq_ok = 1'b1;
						s_next.lt = 1'b0;
						s_next.gt = 1'b0;
						s_next.hit = 1'b0;
						s_next.skip_all = 1'b1;
					end
				end
				// [R20] drive-status query, no interrupt
				else if (s_reg.op[4:0] == FSS_OP_SDS && s_reg.idx == 4'h2)
				begin
					s_next.idx = 4'h8;
					s_next.phase = FSS_RES;
				end
			FSS_MOTOR:
			begin
				// [R8] busy on accept
				s_next.d[s_reg.drv].busy = 1'b1;
				// [R9] motor-on wait
				if (s_reg.mcnt != 24'h0)
					s_next.mcnt = s_reg.mcnt - 24'h1;
				else
				begin
					// [R7] direction and steps
					s_next.d[s_reg.drv].dir = {s_reg.trk_hi, s_reg.trk} >
						{s_reg.d[s_reg.drv].track_hi, s_reg.d[s_reg.drv].track};
					s_next.d[s_reg.drv].stepping = 1'b1;
					s_next.d[s_reg.drv].cnt = 24'h0;
					s_next.dir_out = s_next.d[s_reg.drv].dir;
					// [R10] idle, polling steps
					// [R14] no result phase
					s_next.phase = FSS_IDLE;
				end
			end
			FSS_SCAN:
			begin
				// [R1] [R6] byte compare, MSB first
				if (disk_valid_i && wr && data_sel && !s_reg.hit &&
					!wild(cfg_reg[2], disk_byte_i, host_b) && s_reg.eq_ok &&
					disk_byte_i != host_b)
				begin
					s_next.eq_ok = 1'b0;
					s_next.lt = disk_byte_i < host_b;
					s_next.gt = disk_byte_i > host_b;
				end
				if (disk_sector_end_i)
				begin
					// [R21] deleted sectors ignored
					if (!(s_reg.op[5] && disk_deleted_i))
					begin
						s_next.skip_all = 1'b0;
						case (s_reg.op[4:0])
							FSS_OP_SCAN_LE: s_next.hit = s_reg.eq_ok || s_reg.lt;
							FSS_OP_SCAN_HE: s_next.hit = s_reg.eq_ok || s_reg.gt;
							default: s_next.hit = s_reg.eq_ok;
						endcase
					end
					if (!s_next.hit)
					begin
						s_next.eq_ok = 1'b1;
						s_next.lt = 1'b0;
						s_next.gt = 1'b0;
					end
					// [R5] step by sector step size
					s_next.sec = s_reg.sec + s_reg.step;
				end
				if (s_reg.hit || tc_s[1] || (disk_sector_end_i &&
					s_reg.sec >= s_reg.last && !s_next.hit))
					done_scan = 1'b1;
				if (done_scan)
				begin
					// [R4] [R21] outcome bits
					s_next.st2 = 8'h00;
					if (s_reg.skip_all || !s_reg.hit)
						s_next.st2[FSS_SR2_NOT_BIT] = 1'b1;
					else if (s_reg.eq_ok)
						s_next.st2[FSS_SR2_EQ_BIT] = 1'b1;
					s_next.idx = 4'h0;
					s_next.irq = 1'b1;
					s_next.phase = FSS_RES;
				end
			end
			FSS_RES:
				if (rd && data_sel)
				begin
					s_next.irq = 1'b0;
					// [R3] seven result bytes
					if (s_reg.idx == 4'(FSS_SCAN_RES_LEN) - 4'h1 ||
						s_reg.idx == 4'h8)
						s_next.phase = FSS_IDLE;
					else
						s_next.idx = s_reg.idx + 4'h1;
				end
			default: s_next.phase = FSS_IDLE;
		endcase
		s_next.step_out = s_reg.pcnt != 4'h0;
		if (s_reg.pcnt != 4'h0)
			s_next.pcnt = s_reg.pcnt - 4'h1;
		// [R15] all drives poll in parallel
		for (int i = 0; i < 4; i++)
			if (s_reg.d[i].stepping && s_reg.phase != FSS_MOTOR)
			begin
				if (s_reg.d[i].cnt > 24'h1)
					s_next.d[i].cnt = s_reg.d[i].cnt - 24'h1;
				else if (s_reg.d[i].track == s_reg.trk &&
					s_reg.d[i].track_hi == s_reg.trk_hi)
				begin
					// [R12] interrupt a period after last step
					s_next.d[i].stepping = 1'b0;
					s_next.d[i].busy = 1'b0;
					s_next.irq = 1'b1;
				end
				else
				begin
					// [R11] step rate spacing
					s_next.d[i].cnt = 24'(unit_reg * (5'h10 - cfg_reg[7:4]));
					{s_next.d[i].track_hi, s_next.d[i].track} =
						{s_reg.d[i].track_hi, s_reg.d[i].track} +
						(s_reg.d[i].dir ? 12'h001 : 12'hfff);
					s_next.pcnt = FSS_STEP_PULSE_CYC - 4'h1;
					s_next.step_out = 1'b1;
					s_next.dir_out = s_reg.d[i].dir;
				end
			end
		if (rst_i)
		begin
			s_next = '0;
			s_next.phase = FSS_IDLE;
		end
	end

	always_ff @(posedge clk_i)
		s_reg <= s_next;

	assign wb_dat_o = {24'h000000, s_reg.rdat};
	assign wb_ack_o = s_reg.ack;
	assign step_o = s_reg.step_out;
	assign dir_o = s_reg.dir_out;
	assign irq_o = s_reg.irq;

	// ****************
	// Checks
	// ****************
	// [R8] busy after accept
	busy_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		s_reg.phase == FSS_MOTOR |=> s_reg.d[s_reg.drv].busy)
		else $error("busy not set");
	// [R10] command port free
	seek_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		(s_reg.phase == FSS_MOTOR && s_reg.mcnt == 24'h0) |=>
		s_reg.phase == FSS_IDLE)
		else $error("no idle after motor");
	// [R9] no step during motor
	motor_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		s_reg.phase == FSS_MOTOR && s_reg.pcnt == 4'h0 |=> !step_o)
		else $error("step during motor");
	// [R14] seek gives no result
	seek_nores_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		s_reg.phase == FSS_MOTOR |=> s_reg.phase != FSS_RES)
		else $error("seek result");
	// [R3] result count
	res_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		s_reg.phase == FSS_RES |-> s_reg.idx < 4'h7 || s_reg.idx == 4'h8)
		else $error("result index");
	// [R4] outcome bits exclusive
	scan_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		!(s_reg.st2[2] && s_reg.st2[3]))
		else $error("both outcome bits");
	// [R20] no interrupt from query
	sds_noirq_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
		s_reg.phase == FSS_CMD && s_reg.op[4:0] == FSS_OP_SDS
		&& !$past(s_reg.irq) && s_reg.d == $past(s_reg.d) |=> !irq_o
		|| s_reg.d != $past(s_reg.d))
		else $error("query irq");
	// step pulse width
	step_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(step_o) |=> ##[0:15] !step_o)
		else $error("step stuck");
endmodule // fss_core
`default_nettype wire

// ### tb/fss_drive_model.sv
/*
 Drive stand-in: sector byte stream, sector end, head position.
 Assumes the bench paces sectors and the core steps the head.
*/
`timescale 1ns/10ps
`default_nettype none
module fss_drive_model (
	input wire logic clk_i,
	input wire logic on_i,
	input wire logic [7:0] byte_i,
	input wire logic end_i,
	input wire logic del_i,
	input wire logic [3:0] pins_i,
	input wire logic step_i,
	input wire logic dir_i,
	output logic valid_o,
	output logic [7:0] byte_o,
	output logic end_o,
	output logic del_o,
	output logic tz_o,
	output logic [3:0] pins_o,
	output logic [11:0] trk_o
);
	// ****************
	// Head and stream
	// ****************
	logic [11:0] trk_reg = 12'h000;
	logic step_q = 1'b0;
	logic [7:0] last_reg = 8'h00;
	always_ff @(posedge clk_i)
	begin
		step_q <= step_i;
		if (step_i && !step_q)
			trk_reg <= dir_i ? trk_reg + 12'h001 : trk_reg - 12'h001;
		if (on_i)
			last_reg <= byte_i;
	end
	assign valid_o = on_i;
	assign byte_o = on_i ? byte_i : ~last_reg;
	assign end_o = end_i;
	assign del_o = end_i ? del_i : ~del_i;
	assign tz_o = trk_reg == 12'h000;
	assign pins_o = pins_i;
	assign trk_o = trk_reg;
endmodule // fss_drive_model
`default_nettype wire

// ### tb/testbench.sv
/*
 Self-checking bench for the scan, seek and drive-status core.
 Assumes the core and the drive model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
	import fss_pkg::*;
;
	localparam int UNIT = 4;
	localparam int RATE = 12;
	localparam int IV = UNIT * (16 - RATE);
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, q;
	logic ack, step_o, dir_o, irq_o, dvalid, dend, ddel, tz;
	logic on = 1'b0;
	logic endp = 1'b0;
	logic del_r = 1'b0;
	logic ext_rng = 1'b0;
	logic tcr = 1'b0;
	logic [7:0] dbyte_r = 8'h00;
	logic [7:0] dbyte;
	logic [3:0] pins = 4'h0;
	logic [3:0] pins_w;
	logic [11:0] ptrk;
	int fails = 0;
	int n_tests = 0;
	int cyc_n = 0;
	int irq_t = 0;
	int cur_trk = 0;
	int steps[$];
	logic sdir[$];
	logic step_q = 1'b0;
	logic irq_q = 1'b0;
	logic [7:0] dsk[2][4];
	logic [7:0] hst[4];
	logic dl[2];
	logic [4:0] ops[3] = '{FSS_OP_SCAN_EQ, FSS_OP_SCAN_LE, FSS_OP_SCAN_HE};

	fss_core fss_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
		.wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.disk_valid_i(dvalid), .disk_byte_i(dbyte), .disk_deleted_i(ddel),
		.disk_sector_end_i(dend), .terminal_count_i(tcr),
		.track_zero_i(tz), .drive_pins_i(pins_w), .step_o(step_o),
		.dir_o(dir_o), .irq_o(irq_o));
	fss_drive_model fss_drive_model_inst (.clk_i(clk_i), .on_i(on),
		.byte_i(dbyte_r), .end_i(endp), .del_i(del_r), .pins_i(pins),
		.step_i(step_o), .dir_i(dir_o), .valid_o(dvalid), .byte_o(dbyte),
		.end_o(dend), .del_o(ddel), .tz_o(tz), .pins_o(pins_w),
		.trk_o(ptrk));

	// ****************
	// Helpers
	// ****************
	initial
		forever #50 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc_n <= cyc_n + 1;
		step_q <= step_o;
		irq_q <= irq_o;
		if (step_o && !step_q)
		begin
			steps.push_back(cyc_n);
			sdir.push_back(dir_o);
		end
		if (irq_o && !irq_q)
			irq_t <= cyc_n;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask
	task automatic give_verdict();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i) n++; while (ack !== 1'b1 && n < 50);
		r = rdat;
		chk(ack, 1'b1, "no ack");
		req <= 1'b0;
	endtask
	task automatic wait_res();
		int n;
		n = 0;
		do wb(1'b0, FSS_ADR_MSR, 32'h0, q); while (!q[6] && n++ < 50);
		chk(q[6], 1'b1, "no result");
	endtask
	function automatic int cmpv(logic [7:0] a[4], logic [7:0] b[4],
		logic w);
		for (int i = 0; i < 4; i++)
			if (!(w && (a[i] == 8'hff || b[i] == 8'hff)) && a[i] != b[i])
				return a[i] > b[i] ? 1 : -1;
		return 0;
	endfunction
	function automatic logic met(logic [4:0] op, int c);
		return op == FSS_OP_SCAN_EQ ? c == 0 :
			op == FSS_OP_SCAN_LE ? c <= 0 : c >= 0;
	endfunction

	// ****************
	// Scenarios
	// ****************
	task automatic seek(input logic [11:0] t);
		int n, ns, t0;
		n = 0;
		ns = t > cur_trk ? t - cur_trk : cur_trk - t;
		steps.delete();
		sdir.delete();
		wb(1'b1, FSS_ADR_DATA, {24'h0, FSS_OP_SEEK}, q);
		wb(1'b1, FSS_ADR_DATA, 32'h1, q);
		wb(1'b1, FSS_ADR_DATA, {24'h0, t[7:0]}, q);
		if (ext_rng)
			wb(1'b1, FSS_ADR_DATA, {24'h0, t[11:8], 4'h0}, q);
		t0 = cyc_n;
		while (steps.size() == 0 && n++ < 200)
			@(posedge clk_i);
		wb(1'b0, FSS_ADR_MSR, 32'h0, q);
		chk({q[7], q[4], q[1]}, 3'b101, "busy");
		while (irq_o !== 1'b1 && n++ < 9000)
			@(posedge clk_i);
		@(posedge clk_i);
		chk(steps.size(), ns, "steps");
		chk(steps[0] - t0 >= UNIT - 1, 1'b1, "motor");
		for (int i = 1; i < steps.size(); i++)
			chk(steps[i] - steps[i - 1], IV, "rate");
		foreach (sdir[i])
			chk(sdir[i], t > cur_trk, "dir");
		chk(irq_t - steps[$], IV, "irq");
		chk(ptrk, t, "track");
		wb(1'b0, FSS_ADR_MSR, 32'h0, q);
		chk(q[6], 1'b0, "result");
		wb(1'b0, FSS_ADR_DATA, 32'h0, q);
		@(posedge clk_i);
		chk(irq_o, 1'b0, "irq clr");
		cur_trk = t;
	endtask
	task automatic scan(input int k);
		logic [7:0] cb[9];
		logic [7:0] r[7];
		logic [7:0] trk;
		logic [1:0] e, d;
		logic [4:0] op;
		logic skp, w, h, dens;
		int c;
		op = ops[k % 3];
		w = k >= 8;
		skp = k >= 4 && k < 8;
		h = 1'($urandom);
		dens = 1'($urandom);
		d = 2'($urandom);
		trk = 8'($urandom);
		for (int i = 0; i < 4; i++)
		begin
			hst[i] = 8'($urandom_range(64, 65));
			dsk[0][i] = 8'($urandom_range(64, 65));
			dsk[1][i] = 8'($urandom_range(64, 65));
		end
		dl[0] = skp;
		dl[1] = skp && k != 7;
		if (k < 3)
			dsk[1] = hst;
		if (skp)
			dsk[0] = hst;
		if (w)
		begin
			hst[0] = 8'hff;
			dsk[1][1] = 8'hff;
		end
		cb = '{{1'b0, dens, skp, op}, {5'h0, h, d}, trk, {7'h0, h}, 8'h01,
			8'h02, 8'h03, 8'h1b, 8'h02};
		wb(1'b1, FSS_ADR_CFG, {24'h0, 4'(RATE), 1'b0, w, 2'b00}, q);
		foreach (cb[i])
			wb(1'b1, FSS_ADR_DATA, {24'h0, cb[i]}, q);
		e = 2'b10;
		tcr <= k == 12;
		for (int s = 0; s < 2 && k < 12; s++)
		begin
			for (int i = 0; i < 4; i++)
			begin
				dbyte_r <= dsk[s][i];
				on <= 1'b1;
				wb(1'b1, FSS_ADR_DATA, {24'h0, hst[i]}, q);
			end
			on <= 1'b0;
			endp <= 1'b1;
			del_r <= dl[s];
			@(posedge clk_i);
			endp <= 1'b0;
			c = cmpv(dsk[s], hst, w);
			if (!(skp && dl[s]) && met(op, c))
			begin
				e = c == 0 ? 2'b01 : 2'b00;
				break;
			end
		end
		wait_res();
		tcr <= 1'b0;
		foreach (r[i])
		begin
			wb(1'b0, FSS_ADR_DATA, 32'h0, q);
			r[i] = q[7:0];
		end
		chk(r[0][2:0], {h, d}, "st0");
		chk(r[2][3:2], e, "st2");
		chk(r[3], trk, "trk");
		chk(r[4], h, "head");
		chk(r[6], 8'h02, "size");
		wb(1'b0, FSS_ADR_MSR, 32'h0, q);
		chk(q[7:6], 2'b10, "count");
	endtask

	initial
	begin
		void'($urandom(32'hc338));
		pins = 4'($urandom);
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({step_o, dir_o, irq_o}, 3'b000, "reset");
		wb(1'b0, FSS_ADR_MSR, 32'h0, q);
		chk({q[7], q[4:0]}, 6'h20, "msr reset");
		wb(1'b0, 4'h2, 32'h0, q);
		chk(q, 32'h0, "unmapped");
		wb(1'b1, FSS_ADR_DRV, UNIT, q);
		wb(1'b1, FSS_ADR_CFG, {24'h0, 4'(RATE), 4'h0}, q);
		seek(12'h02b);
		seek(12'h005);
		ext_rng = 1'b1;
		wb(1'b1, FSS_ADR_CFG, {24'h0, 4'(RATE), 4'h8}, q);
		seek(12'h102);
		seek(12'h000);
		chk(tz, 1'b1, "zero");
		ext_rng = 1'b0;
		wb(1'b1, FSS_ADR_DATA, {27'h0, FSS_OP_SDS}, q);
		wb(1'b1, FSS_ADR_DATA, 32'h5, q);
		wait_res();
		wb(1'b0, FSS_ADR_DATA, 32'h0, q);
		chk({q[3:0], irq_o}, {pins[3], 3'b101, 1'b0}, "drive");
		for (int k = 0; k < 13; k++)
			scan(k);
		give_verdict();
	end
	initial
	begin
		#4ms;
		fails++;
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
